// File: src/bridge_cfg_regs.sv
// Bridge configuration registers for bus numbers, secondary timer and I/O base
`timescale 1ns/1ps
module bridge_cfg_regs (
   input  wire logic                        SYS_CLK,
   input  wire logic                        RST_N,
   // ******************************************
   // Configuration access
   // ******************************************
   input  wire bridge_cfg_pkg::cfg_access_t CFG_REQ,
   input  wire logic                        CFG_VALID,
   output logic [31:0]                      CFG_RDATA,
   output logic                             CFG_ACK,
   // ******************************************
   // Window limit and upper address
   // ******************************************
   // Held in neighbouring registers outside this block
   input  wire logic [3:0]                  IO_WINDOW_TOP_BITS,
   input  wire logic [15:0]                 IO_UPPER_BITS,
   // ******************************************
   // Cycles to be decoded
   // ******************************************
   input  wire logic                        PRI_TYPE1_VALID,
   input  wire logic [7:0]                  PRI_TYPE1_BUS,
   input  wire logic                        SEC_TYPE1_VALID,
   input  wire logic [7:0]                  SEC_TYPE1_BUS,
   input  wire logic                        IO_CYCLE_VALID,
   input  wire logic [31:0]                 IO_CYCLE_ADDR,
   // ******************************************
   // Own secondary master transaction
   // ******************************************
   input  wire logic                        SEC_FRAME_START,
   input  wire logic                        SEC_MASTER_BUSY,
   input  wire logic                        SEC_GRANT,
   input  wire logic [3:0]                  SEC_COMMAND,
   // ******************************************
   // Registered decode results
   // ******************************************
   output logic                             PRI_CLAIM_TO_TYPE0,
   output logic                             PRI_CLAIM_TO_TYPE1,
   output logic                             SEC_TO_SPECIAL,
   output logic                             SEC_PASS_UPSTREAM,
   output logic                             IO_FORWARD,
   output logic                             SEC_END_AFTER_PHASE
);
   // ******************************************
   // Block state
   // ******************************************
   typedef struct packed {
      bridge_cfg_pkg::cfg_regs_t regs;
      logic [31:0]               rdata;
      logic                      ack;
      logic                      to_type0;
      logic                      to_type1;
      logic                      to_special;
      logic                      upstream;
      logic                      io_fwd;
   } state_t;

   state_t cur;
   state_t next_cur;
   logic   timer_end;

   // ******************************************
   // Read-back and range helpers
   // ******************************************
   // Limit nibble is read back from its input; only the base is stored here
   function automatic logic [31:0] read_word(input bridge_cfg_pkg::cfg_regs_t r, input logic [7:0] off);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (off == bridge_cfg_pkg::BUS_NUM_OFFSET) begin
         w = {r.downstream_master_timer, 3'h0,
              r.highest_bus_behind, r.downstream_bus_index, r.upstream_bus_index};
      end else if (off == bridge_cfg_pkg::IO_BASE_OFFSET) begin
         w = {16'h0000, IO_WINDOW_TOP_BITS, bridge_cfg_pkg::IO_DECODE_32,
              r.io_window_bottom, bridge_cfg_pkg::IO_DECODE_32};
      end
      return w;
   endfunction

   function automatic logic in_bus_range(input bridge_cfg_pkg::cfg_regs_t r, input logic [7:0] bus);
      return (bus > r.downstream_bus_index) && (bus <= r.highest_bus_behind);
   endfunction

   // ******************************************
   // Register update and cycle decode
   // ******************************************
   always_comb begin
      logic [31:0] lo;
      logic [31:0] hi;
      lo       = {IO_UPPER_BITS, cur.regs.io_window_bottom, 12'h000};
      hi       = {IO_UPPER_BITS, IO_WINDOW_TOP_BITS, 12'hFFF};
      next_cur = cur;
      // Every access is acknowledged, refused ones too
      next_cur.ack   = CFG_VALID;
      next_cur.rdata = 32'h0000_0000;
      if (CFG_VALID && !CFG_REQ.write) begin
         next_cur.rdata = read_word(cur.regs, CFG_REQ.offset);
      end
      // Byte by byte; read-only bits have no storage to hit
      if (CFG_VALID && CFG_REQ.write) begin
         if (CFG_REQ.offset == bridge_cfg_pkg::BUS_NUM_OFFSET) begin
            if (!CFG_REQ.upstream_cmd_byte_en_n[0]) begin
               next_cur.regs.upstream_bus_index = CFG_REQ.data[7:0];
            end
            if (!CFG_REQ.upstream_cmd_byte_en_n[1]) begin
               next_cur.regs.downstream_bus_index = CFG_REQ.data[15:8];
            end
            if (!CFG_REQ.upstream_cmd_byte_en_n[2]) begin
               next_cur.regs.highest_bus_behind = CFG_REQ.data[23:16];
            end
            if (!CFG_REQ.upstream_cmd_byte_en_n[3]) begin
               next_cur.regs.downstream_master_timer = CFG_REQ.data[31:bridge_cfg_pkg::TIMER_LSB];
            end
         end else if (CFG_REQ.offset == bridge_cfg_pkg::IO_BASE_OFFSET) begin
            if (!CFG_REQ.upstream_cmd_byte_en_n[0]) begin
               next_cur.regs.io_window_bottom = CFG_REQ.data[7:4];
            end
         end
      end
      // Decode of bus-numbered configuration cycles and of I/O cycles against the window
      next_cur.to_type0   = PRI_TYPE1_VALID && PRI_TYPE1_BUS == cur.regs.downstream_bus_index;
      next_cur.to_type1   = PRI_TYPE1_VALID && in_bus_range(cur.regs, PRI_TYPE1_BUS);
      next_cur.to_special = SEC_TYPE1_VALID && SEC_TYPE1_BUS == cur.regs.upstream_bus_index;
      next_cur.upstream   = SEC_TYPE1_VALID && SEC_TYPE1_BUS != cur.regs.upstream_bus_index &&
                            !(SEC_TYPE1_BUS >= cur.regs.downstream_bus_index &&
                              SEC_TYPE1_BUS <= cur.regs.highest_bus_behind);
      next_cur.io_fwd     = IO_CYCLE_VALID && IO_CYCLE_ADDR >= lo && IO_CYCLE_ADDR <= hi;
   end

   // ******************************************
   // State register
   // ******************************************
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cur <= '{regs: '{upstream_bus_index:      bridge_cfg_pkg::BUS_RESET,
                          downstream_bus_index:    bridge_cfg_pkg::BUS_RESET,
                          highest_bus_behind:      bridge_cfg_pkg::BUS_RESET,
                          downstream_master_timer: bridge_cfg_pkg::TIMER_RESET,
                          io_window_bottom:        bridge_cfg_pkg::IO_BASE_RESET},
                  rdata:   32'h0000_0000,
                  default: 1'b0};
      end else begin
         cur <= next_cur;
      end
   end

   // ******************************************
   // Secondary master timer
   // ******************************************
   bridge_timer u_timer (
      .sys_clk         (SYS_CLK),
      .rst_n           (RST_N),
      .timer_value     (cur.regs.downstream_master_timer),
      .frame_start     (SEC_FRAME_START),
      .master_busy     (SEC_MASTER_BUSY),
      .grant           (SEC_GRANT),
      .command         (SEC_COMMAND),
      .end_after_phase (timer_end)
   );

   // ******************************************
   // Outputs
   // ******************************************
   assign CFG_RDATA           = cur.rdata;
   assign CFG_ACK             = cur.ack;
   assign PRI_CLAIM_TO_TYPE0  = cur.to_type0;
   assign PRI_CLAIM_TO_TYPE1  = cur.to_type1;
   assign SEC_TO_SPECIAL      = cur.to_special;
   assign SEC_PASS_UPSTREAM   = cur.upstream;
   assign IO_FORWARD          = cur.io_fwd;
   assign SEC_END_AFTER_PHASE = timer_end;
endmodule

// File: src/bridge_cfg_pkg.sv
// Constants and carrier types for the bridge bus number and I/O base registers
//
// Behaviour
// - Upstream bus index, byte 0 of 0x18, RW, reset 0, steers secondary Type 1 decode.
// - Downstream bus index, bits 15:8, RW, reset 0, steers primary Type 1 claim.
// - Highest bus behind, bits 23:16, RW, reset 0, bounds downstream Type 1 forwarding.
// - Secondary master timer counts clocks from frame start, expiry from bits 31:27.
// - Bits 26:24 of the timer byte read zero and ignore writes.
// - Timer zero with grant removed ends after first data phase, except MWI.
// - I/O base bits 7:4 give address 15:12, low 12 zero, upper 16 external.
// - I/O window has 4 KB granularity and decides which I/O cycles forward.
// - Bits 3:0 of I/O base read fixed 0x1 for 32-bit I/O decode.
// - I/O limit field at address 15:12 closes the top of the window.
package bridge_cfg_pkg;
   // ******************************************
   // Offsets, reset values and commands
   // ******************************************
   localparam logic [7:0] BUS_NUM_OFFSET    = 8'h18;
   localparam logic [7:0] IO_BASE_OFFSET    = 8'h1C;
   localparam int         TIMER_LSB         = 27;
   localparam int         TIMER_STEP_BITS   = 3;
   localparam logic [7:0] BUS_RESET         = 8'h00;
   localparam logic [4:0] TIMER_RESET       = 5'h00;
   localparam logic [3:0] IO_BASE_RESET     = 4'h0;
   localparam logic [3:0] IO_LIMIT_RESET    = 4'h0;
   localparam logic [3:0] IO_DECODE_32      = 4'h1;
   localparam logic [3:0] CMD_MWI           = 4'hF;
   localparam logic [3:0] CMD_IO_READ       = 4'h2;
   localparam logic [3:0] CMD_IO_WRITE      = 4'h3;

   // ******************************************
   // Carrier types
   // ******************************************
   typedef struct packed {
      logic [7:0] upstream_bus_index;
      logic [7:0] downstream_bus_index;
      logic [7:0] highest_bus_behind;
      logic [4:0] downstream_master_timer;
      logic [3:0] io_window_bottom;
   } cfg_regs_t;

   typedef struct packed {
      logic        write;
      logic [7:0]  offset;
      logic [3:0]  upstream_cmd_byte_en_n;
      logic [31:0] data;
   } cfg_access_t;

   typedef enum logic [1:0] {
      MT_IDLE    = 2'b00,
      MT_RUN     = 2'b01,
      MT_EXPIRED = 2'b11
   } timer_state_t;
endpackage

// File: src/bridge_timer.sv
// Secondary master latency timer
`timescale 1ns/1ps
module bridge_timer (
   input  wire logic                        sys_clk,
   input  wire logic                        rst_n,
   input  wire logic [4:0]                  timer_value,
   input  wire logic                        frame_start,
   input  wire logic                        master_busy,
   input  wire logic                        grant,
   input  wire logic [3:0]                  command,
   output logic                             end_after_phase
);
   // ******************************************
   // Timer state
   // ******************************************
   typedef struct packed {
      bridge_cfg_pkg::timer_state_t state;
      logic [7:0]                   count;
      logic                         stop;
   } timer_t;

   timer_t cur;
   timer_t next_cur;
   logic [7:0] limit;

   // ******************************************
   // Next state
   // ******************************************
   // Count starts at one on the edge that sees the frame
   always_comb begin
      limit    = {timer_value, 3'h0};
      next_cur = cur;
      unique case (cur.state)
         bridge_cfg_pkg::MT_IDLE: begin
            next_cur.count = 8'h00;
            if (frame_start) begin
               next_cur.state = bridge_cfg_pkg::MT_RUN;
               next_cur.count = 8'h01;
            end
         end
         bridge_cfg_pkg::MT_RUN: begin
            if (cur.count >= limit) begin
               next_cur.state = bridge_cfg_pkg::MT_EXPIRED;
            end else begin
               next_cur.count = cur.count + 8'h01;
            end
         end
         bridge_cfg_pkg::MT_EXPIRED: begin
         end
         default: next_cur.state = bridge_cfg_pkg::MT_IDLE;
      endcase
      if (!master_busy) begin
         next_cur.state = bridge_cfg_pkg::MT_IDLE;
      end
      // Expired timer or zero value, grant gone, not MWI
      next_cur.stop = master_busy && !grant && (command != bridge_cfg_pkg::CMD_MWI) &&
                      (timer_value == 5'h00 || next_cur.state == bridge_cfg_pkg::MT_EXPIRED);
   end

   // ******************************************
   // State register
   // ******************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '{bridge_cfg_pkg::MT_IDLE, 8'h00, 1'b0};
      end else begin
         cur <= next_cur;
      end
   end

   assign end_after_phase = cur.stop;
endmodule

// File: tb/bridge_cfg_regs_properties.sv
// Checker for the bridge bus number, timer and I/O base registers
`timescale 1ns/1ps
module bridge_cfg_regs_checker (
   input wire logic                        SYS_CLK,
   input wire logic                        RST_N,
   input wire bridge_cfg_pkg::cfg_access_t CFG_REQ,
   input wire logic                        CFG_VALID,
   input wire logic [31:0]                 CFG_RDATA,
   input wire logic                        CFG_ACK,
   input wire logic                        PRI_TYPE1_VALID,
   input wire logic                        IO_CYCLE_VALID,
   input wire logic                        SEC_MASTER_BUSY,
   input wire logic                        SEC_GRANT,
   input wire logic [3:0]                  SEC_COMMAND,
   input wire logic                        PRI_CLAIM_TO_TYPE0,
   input wire logic                        PRI_CLAIM_TO_TYPE1,
   input wire logic                        IO_FORWARD,
   input wire logic                        SEC_END_AFTER_PHASE
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   // ******************************************
   // Properties
   // ******************************************
   property p_ack; CFG_VALID |=> CFG_ACK; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_quiet; !CFG_VALID |=> !CFG_ACK; endproperty
   a_quiet: assert property (p_quiet) else $error("stray ack");
   property p_cap; CFG_VALID && !CFG_REQ.write && CFG_REQ.offset == 8'h1C |=> CFG_RDATA[3:0] == 4'h1; endproperty
   a_cap: assert property (p_cap) else $error("decode width code");
   property p_ro; CFG_VALID && !CFG_REQ.write && CFG_REQ.offset == 8'h18 |=> CFG_RDATA[26:24] == 3'h0; endproperty
   a_ro: assert property (p_ro) else $error("timer low bits");
   property p_excl; !(PRI_CLAIM_TO_TYPE0 && PRI_CLAIM_TO_TYPE1); endproperty
   a_excl: assert property (p_excl) else $error("double claim");
   property p_claim; PRI_CLAIM_TO_TYPE0 || PRI_CLAIM_TO_TYPE1 |-> $past(PRI_TYPE1_VALID); endproperty
   a_claim: assert property (p_claim) else $error("claim no cycle");
   property p_fwd; IO_FORWARD |-> $past(IO_CYCLE_VALID); endproperty
   a_fwd: assert property (p_fwd) else $error("forward no cycle");
   property p_end; SEC_END_AFTER_PHASE |-> $past(SEC_MASTER_BUSY && !SEC_GRANT && SEC_COMMAND != 4'hF); endproperty
   a_end: assert property (p_end) else $error("end without cause");
   property p_mwi; SEC_COMMAND == 4'hF |=> !SEC_END_AFTER_PHASE; endproperty
   a_mwi: assert property (p_mwi) else $error("end during MWI");
   property p_hi; CFG_VALID && !CFG_REQ.write && CFG_REQ.offset == 8'h1C |=> CFG_RDATA[31:16] == 16'h0000; endproperty
   a_hi: assert property (p_hi) else $error("upper half not zero");
   // ******************************************
   // Covers
   // ******************************************
   c_rd: cover property (CFG_ACK && CFG_RDATA != 32'h0);
   c_end: cover property (SEC_END_AFTER_PHASE);
   c_fwd: cover property (IO_FORWARD);
endmodule
bind bridge_cfg_regs bridge_cfg_regs_checker u_bridge_cfg_regs_checker (
   .SYS_CLK             (SYS_CLK),
   .RST_N               (RST_N),
   .CFG_REQ             (CFG_REQ),
   .CFG_VALID           (CFG_VALID),
   .CFG_RDATA           (CFG_RDATA),
   .CFG_ACK             (CFG_ACK),
   .PRI_TYPE1_VALID     (PRI_TYPE1_VALID),
   .IO_CYCLE_VALID      (IO_CYCLE_VALID),
   .SEC_MASTER_BUSY     (SEC_MASTER_BUSY),
   .SEC_GRANT           (SEC_GRANT),
   .SEC_COMMAND         (SEC_COMMAND),
   .PRI_CLAIM_TO_TYPE0  (PRI_CLAIM_TO_TYPE0),
   .PRI_CLAIM_TO_TYPE1  (PRI_CLAIM_TO_TYPE1),
   .IO_FORWARD          (IO_FORWARD),
   .SEC_END_AFTER_PHASE (SEC_END_AFTER_PHASE)
);

// File: tb/sec_master_model.sv
// Secondary bus master model giving frame start and ownership
`timescale 1ns/1ps
module sec_master_model (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic start,
   input  wire logic stop,
   output logic      frame_start,
   output logic      busy
);
   // ******************************************
   // Frame pulse and ownership
   // ******************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_start <= 1'b0;
         busy        <= 1'b0;
      end else begin
         frame_start <= start;
         busy        <= start | (busy & ~stop);
      end
   end
endmodule

// File: tb/bridge_cfg_regs_bench.sv
// Self-checking bench for the bridge configuration registers
`timescale 1ns/1ps
module bridge_cfg_regs_bench;
   logic SYS_CLK = 0, RST_N = 0, CFG_VALID = 0, PRI_TYPE1_VALID = 0, SEC_TYPE1_VALID = 0, IO_CYCLE_VALID = 0;
   logic SEC_GRANT = 1, start = 0, stop = 0, CFG_ACK, SEC_FRAME_START, SEC_MASTER_BUSY, SEC_END_AFTER_PHASE;
   logic PRI_CLAIM_TO_TYPE0, PRI_CLAIM_TO_TYPE1, SEC_TO_SPECIAL, SEC_PASS_UPSTREAM, IO_FORWARD;
   logic [7:0] PRI_TYPE1_BUS = 8'h00, SEC_TYPE1_BUS = 8'h00;
   logic [31:0] IO_CYCLE_ADDR = 32'h0, CFG_RDATA, rd;
   logic [3:0] SEC_COMMAND = 4'h0, IO_WINDOW_TOP_BITS = 4'hA;
   logic [15:0] IO_UPPER_BITS = 16'h0001;
   bridge_cfg_pkg::cfg_access_t CFG_REQ = '0;
   int fails = 0, comparisons = 0;
   always #20 SYS_CLK = ~SYS_CLK;
   bridge_cfg_regs u_bridge_cfg_regs (
      .SYS_CLK             (SYS_CLK),
      .RST_N               (RST_N),
      .CFG_REQ             (CFG_REQ),
      .CFG_VALID           (CFG_VALID),
      .CFG_RDATA           (CFG_RDATA),
      .CFG_ACK             (CFG_ACK),
      .IO_WINDOW_TOP_BITS  (IO_WINDOW_TOP_BITS),
      .IO_UPPER_BITS       (IO_UPPER_BITS),
      .PRI_TYPE1_VALID     (PRI_TYPE1_VALID),
      .PRI_TYPE1_BUS       (PRI_TYPE1_BUS),
      .SEC_TYPE1_VALID     (SEC_TYPE1_VALID),
      .SEC_TYPE1_BUS       (SEC_TYPE1_BUS),
      .IO_CYCLE_VALID      (IO_CYCLE_VALID),
      .IO_CYCLE_ADDR       (IO_CYCLE_ADDR),
      .SEC_FRAME_START     (SEC_FRAME_START),
      .SEC_MASTER_BUSY     (SEC_MASTER_BUSY),
      .SEC_GRANT           (SEC_GRANT),
      .SEC_COMMAND         (SEC_COMMAND),
      .PRI_CLAIM_TO_TYPE0  (PRI_CLAIM_TO_TYPE0),
      .PRI_CLAIM_TO_TYPE1  (PRI_CLAIM_TO_TYPE1),
      .SEC_TO_SPECIAL      (SEC_TO_SPECIAL),
      .SEC_PASS_UPSTREAM   (SEC_PASS_UPSTREAM),
      .IO_FORWARD          (IO_FORWARD),
      .SEC_END_AFTER_PHASE (SEC_END_AFTER_PHASE)
   );
   sec_master_model u_sec_master_model (.clk(SYS_CLK), .rst_n(RST_N), .start(start), .stop(stop),
      .frame_start(SEC_FRAME_START), .busy(SEC_MASTER_BUSY));
   // ******************************************
   // Check and access tasks
   // ******************************************
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task cfg(input logic w, input logic [7:0] off, input logic [3:0] be, input logic [31:0] d);
      @(posedge SYS_CLK);
      CFG_REQ <= '{w, off, be, d};
      CFG_VALID <= 1'b1;
      @(posedge SYS_CLK);
      CFG_VALID <= 1'b0;
      // Taken here; acknowledge and read data stand for one cycle
      #1;
      rd = CFG_RDATA;
      chk("ack", {31'h0, CFG_ACK}, 32'h1);
   endtask
   task dec(input logic [7:0] p, input logic [7:0] s, input logic [31:0] a, input logic [4:0] e);
      @(posedge SYS_CLK);
      {PRI_TYPE1_VALID, PRI_TYPE1_BUS, SEC_TYPE1_VALID, SEC_TYPE1_BUS} <= {1'b1, p, 1'b1, s};
      {IO_CYCLE_VALID, IO_CYCLE_ADDR} <= {1'b1, a};
      @(posedge SYS_CLK);
      {PRI_TYPE1_VALID, SEC_TYPE1_VALID, IO_CYCLE_VALID} <= 3'b000;
      #1;
      chk("decode", {27'h0, PRI_CLAIM_TO_TYPE0, PRI_CLAIM_TO_TYPE1, SEC_TO_SPECIAL, SEC_PASS_UPSTREAM, IO_FORWARD},
         {27'h0, e});
   endtask
   task tmr(input logic [31:0] v, input logic [3:0] c, input int n, input logic e);
      cfg(1'b1, 8'h18, 4'h7, v);
      @(posedge SYS_CLK);
      SEC_COMMAND <= c;
      SEC_GRANT <= 1'b0;
      start <= 1'b1;
      @(posedge SYS_CLK);
      start <= 1'b0;
      repeat (n) @(posedge SYS_CLK);
      #1;
      chk("end", {31'h0, SEC_END_AFTER_PHASE}, {31'h0, e});
      @(posedge SYS_CLK);
      stop <= 1'b1;
      SEC_GRANT <= 1'b1;
      @(posedge SYS_CLK);
      stop <= 1'b0;
   endtask
   task close_out;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ******************************************
   // Watchdog and tests
   // ******************************************
   initial begin
      repeat (2000) @(posedge SYS_CLK);
      fails++;
      close_out();
   end
   initial begin
      repeat (12) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      cfg(1'b0, 8'h18, 4'h0, 32'h0);
      chk("bus_reset", rd, 32'h0);
      cfg(1'b0, 8'h1C, 4'h0, 32'h0);
      chk("io_reset", rd, 32'h0000A101);
      cfg(1'b1, 8'h18, 4'h0, 32'hFF0A0503);
      cfg(1'b1, 8'h18, 4'hE, 32'h00000011);
      cfg(1'b0, 8'h18, 4'h0, 32'h0);
      chk("bus_write", rd, 32'hF80A0511);
      cfg(1'b1, 8'h1C, 4'h0, 32'hFFFFFF3F);
      cfg(1'b1, 8'h20, 4'h0, 32'hFFFFFFFF);
      cfg(1'b0, 8'h1C, 4'h0, 32'h0);
      chk("io_write", rd, 32'h0000A131);
      cfg(1'b0, 8'h20, 4'h0, 32'h0);
      chk("unmapped", rd, 32'h0);
      dec(8'h05, 8'h11, 32'h00013000, 5'h15);
      dec(8'h0A, 8'h07, 32'h0001AFFF, 5'h09);
      dec(8'h0B, 8'h20, 32'h00012FFF, 5'h02);
      dec(8'h04, 8'h05, 32'h0001B000, 5'h00);
      tmr(32'h0, 4'h7, 3, 1'b1);
      tmr(32'h0, 4'hF, 3, 1'b0);
      // Count reaches eight one edge before the registered end shows
      tmr(32'h08000000, 4'h7, 8, 1'b0);
      tmr(32'h08000000, 4'h7, 9, 1'b1);
      @(posedge SYS_CLK);
      RST_N <= 1'b0;
      repeat (3) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      cfg(1'b0, 8'h18, 4'h0, 32'h0);
      chk("bus_rerun", rd, 32'h0);
      cfg(1'b0, 8'h1C, 4'h0, 32'h0);
      chk("io_rerun", rd, 32'h0000A101);
      close_out();
   end
endmodule
